// ### src/swp_consts.svh
/*
  offsets, field positions, reset values and timing figures of the switch
  power and link power control block.
  assumes a 32-bit register word and an 8-bit byte address.
*/
`ifndef SWP_CONSTS_SVH
`define SWP_CONSTS_SVH

// address map, one group of four words per port
`define SWP_ADDR_W        8
`define SWP_PORT_STRIDE   8'h10
`define SWP_OFS_PM_CONTROL_STATUS_REG     8'h00
`define SWP_OFS_LINKCTL   8'h04
`define SWP_OFS_PMVEND    8'h08
`define SWP_OFS_STATUS    8'h0C

// power state field, two bits at the bottom of the control/status word
`define SWP_PS_LSB        0
`define SWP_PS_MSB        1
`define SWP_PS_D0         2'h0
`define SWP_PS_D3HOT      2'h3

// link control: aspm field
`define SWP_ASPM_L0S_BIT  0
`define SWP_ASPM_L1_BIT   1
`define SWP_ASPM_RST      2'h0

// vendor control: entry timers, counted in clock cycles
`define SWP_L0S_TMR_LSB   0
`define SWP_L1_TMR_LSB    8
`define SWP_TMR_W         8
`define SWP_L0S_TMR_RST   8'h10
`define SWP_L1_TMR_RST    8'h40

// status word: write side command and read side fields
`define SWP_CFG_DONE_BIT  0
`define SWP_ST_DSTATE_LSB 0
`define SWP_ST_LINK_LSB   4
`define SWP_ST_DEVLP_BIT  9

`endif

// ### src/swp_pkg.sv
/*
  types of the switch power and link power control block.
  takes no constant from swp_consts.svh; the state encodings are set here.
*/
package swp_pkg;

  // device power state, one-hot
  typedef enum logic [3:0] {
    SWP_D0_UNINIT = 4'h1,
    SWP_D0_ACTIVE = 4'h2,
    SWP_D3_HOT    = 4'h4,
    SWP_D3_COLD   = 4'h8
  } swpDState_t;

  // link power state, one-hot; l1 pending means still in l0/l0s awaiting ack
  typedef enum logic [4:0] {
    SWP_LK_L0     = 5'h01,
    SWP_LK_L0S    = 5'h02,
    SWP_LK_L1PEND = 5'h04,
    SWP_LK_L1     = 5'h08,
    SWP_LK_L23    = 5'h10
  } swpLink_t;

  // per port outputs towards the link layer
  typedef struct packed {
    swpLink_t linkState;   // current link power state
    logic     l1Req;       // asking the partner for l1
    logic     l1Permit;    // d3hot lets the link go to l1
    logic     pmeOk;       // pme messages may be generated
    logic     trafficStop; // no tlp or dllp may pass
  } swpPortStat_t;

  // per port inputs from the link layer
  typedef struct packed {
    logic idle;    // entry conditions for l0s/l1 hold this cycle
    logic peerL1;  // partner acks (port a) or asks (port c) l1
  } swpPortIn_t;

endpackage

// ### src/swp_power_ctrl.sv
/*
  power state tracking and active state link power control for the two
  bridge ports of a switch: port 0 is the upstream root port, port 1 the
  non-transparent port.
  assumes link layer inputs on sys_clk, a power-removed pin from outside,
  and a register master on a plain strobe port with read data one cycle later.
*/
// Operation
// - each bridge state affects only its port
// - d3hot lets that port's link enter l1
// - root low power plus ack: whole switch low
// - four states: d0 uninit, d0 active, d3hot, d3cold
// - d3hot to d0 resets no logic, registers
// - reset gives d0 uninit; configuration gives active
// - writing d3hot code from active enters d3hot
// - writing d0 code from d3hot gives uninit
// - no pme messages in d3hot or d3cold
// - l2/l3 ready only after ack, no traffic
// - l0s both ports, l1 aspm port a only
// - enabled aspm acts without software help
// - l0s after conditions held l0s timer
// - l1 after conditions held l1 timer
// - met conditions in l0/l0s send l1 request
// - only the upstream port requests l1
// - l1 only on partner ack, else stay
// - d3hot also drives the link into l1
`include "swp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module swp_power_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic [`SWP_ADDR_W-1:0]      regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  input  wire swp_pkg::swpPortIn_t [1:0]   portIn,
  input  wire logic                        turnOffAck,
  input  wire logic                        powerRemoved,
  output swp_pkg::swpPortStat_t [1:0]      portStat,
  output logic                             deviceLowPower
);

  // reset release copy
  logic       rstMeta_r;          // first release stage
  logic       rstSync_n;          // released reset used everywhere
  // power-removed pin filter
  logic [2:0] pwrSync_r;          // three stage pin capture
  logic       pwrGone_r;          // filtered level
  // shared device state
  logic       toAck_r;            // turn-off acknowledge seen
  logic       devLp_r;            // whole switch in low power
  // per port state
  swp_pkg::swpDState_t       dState_r  [2];
  swp_pkg::swpLink_t         linkSt_r  [2];
  logic [1:0]                aspm_r    [2];
  logic [`SWP_TMR_W-1:0]     l0sTmr_r  [2];
  logic [`SWP_TMR_W-1:0]     l1Tmr_r   [2];
  logic [`SWP_TMR_W-1:0]     idleCnt_r [2];
  // decoded register access
  logic                      hitPort;  // port index of access
  logic [1:0]                hitReg;   // word within port group
  logic                      addrOk;   // address is mapped
  logic [31:0]               rdNxt;    // read data before the flop

  // two flop release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // pin capture; only stages two and three are compared
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pwrSync_r <= 3'h0;
      pwrGone_r <= 1'b0;
    end else begin
      pwrSync_r <= {pwrSync_r[1:0], powerRemoved};
      if (pwrSync_r[1] == pwrSync_r[2]) begin
        pwrGone_r <= pwrSync_r[2];
      end
    end
  end

  // address decode: any bit outside the map makes it unmapped
  assign hitPort = regAddr[4];
  assign hitReg  = regAddr[3:2];
  assign addrOk  = (regAddr[7:5] == 3'h0) && (regAddr[1:0] == 2'h0);

  // turn-off acknowledge sticky flag, set wins over the clear
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      toAck_r <= 1'b0;
    end else if (turnOffAck) begin
      toAck_r <= 1'b1;
    end else if (dState_r[0] == swp_pkg::SWP_D0_UNINIT ||
                 dState_r[0] == swp_pkg::SWP_D0_ACTIVE) begin
      toAck_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      devLp_r <= 1'b0;
    end else begin
      devLp_r <= toAck_r && (dState_r[0] == swp_pkg::SWP_D3_HOT ||
                             dState_r[0] == swp_pkg::SWP_D3_COLD);
    end
  end

  // switch-wide low power output
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      deviceLowPower <= 1'b0;
    end else begin
      deviceLowPower <= devLp_r;
    end
  end

  // per port logic; each copy sees its own registers plus the shared devLp_r
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic wrHit;     // write to this port's group
    logic psWrD0;    // power state field written with d0
    logic psWrD3;    // power state field written with d3hot
    logic l0sGo;     // l0s entry conditions held long enough
    logic l1Go;      // l1 aspm conditions held long enough
    logic l1Want;    // any reason to head for l1

    assign wrHit  = regWr && addrOk && (hitPort == 1'(p));
    assign psWrD0 = wrHit && (hitReg == 2'h0) &&
                    (regWdata[`SWP_PS_MSB:`SWP_PS_LSB] == `SWP_PS_D0);
    assign psWrD3 = wrHit && (hitReg == 2'h0) &&
                    (regWdata[`SWP_PS_MSB:`SWP_PS_LSB] == `SWP_PS_D3HOT);
    assign l0sGo  = aspm_r[p][`SWP_ASPM_L0S_BIT] && portIn[p].idle &&
                    (idleCnt_r[p] >= l0sTmr_r[p]);
    assign l1Go   = aspm_r[p][`SWP_ASPM_L1_BIT] && portIn[p].idle &&
                    (idleCnt_r[p] >= l1Tmr_r[p]);
    assign l1Want = l1Go || (dState_r[p] == swp_pkg::SWP_D3_HOT);

    // link control and vendor timers; never touched by state moves
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        aspm_r[p]   <= `SWP_ASPM_RST;
        l0sTmr_r[p] <= `SWP_L0S_TMR_RST;
        l1Tmr_r[p]  <= `SWP_L1_TMR_RST;
      end else begin
        if (wrHit && hitReg == 2'h1) begin
          // l1 aspm bit kept zero on port c
          aspm_r[p] <= {regWdata[`SWP_ASPM_L1_BIT] & (p == 0),
                        regWdata[`SWP_ASPM_L0S_BIT]};
        end
        if (wrHit && hitReg == 2'h2) begin
          l0sTmr_r[p] <= regWdata[`SWP_L0S_TMR_LSB +: `SWP_TMR_W];
          l1Tmr_r[p]  <= regWdata[`SWP_L1_TMR_LSB +: `SWP_TMR_W];
        end
      end
    end

    // idle run length, saturating; any activity restarts it
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        idleCnt_r[p] <= '0;
      end else if (!portIn[p].idle) begin
        idleCnt_r[p] <= '0;
      end else if (idleCnt_r[p] != {`SWP_TMR_W{1'b1}}) begin
        idleCnt_r[p] <= idleCnt_r[p] + `SWP_TMR_W'(1);
      end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        dState_r[p] <= swp_pkg::SWP_D0_UNINIT;
      end else begin
        unique case (dState_r[p])
          swp_pkg::SWP_D0_UNINIT: begin
            if (wrHit && hitReg == 2'h3 && regWdata[`SWP_CFG_DONE_BIT]) begin
              dState_r[p] <= swp_pkg::SWP_D0_ACTIVE;
            end
          end
          swp_pkg::SWP_D0_ACTIVE: begin
            if (psWrD3) begin
              dState_r[p] <= swp_pkg::SWP_D3_HOT;
            end
          end
          // d0 write, nothing else is reset
          swp_pkg::SWP_D3_HOT: begin
            if (pwrGone_r) begin
              dState_r[p] <= swp_pkg::SWP_D3_COLD;
            end else if (psWrD0) begin
              dState_r[p] <= swp_pkg::SWP_D0_UNINIT;
            end
          end
          // only a fresh fundamental reset leaves d3cold
          swp_pkg::SWP_D3_COLD: begin
            dState_r[p] <= swp_pkg::SWP_D3_COLD;
          end
        endcase
      end
    end

    // link state machine runs on its own once enabled
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        linkSt_r[p] <= swp_pkg::SWP_LK_L0;
      end else if (devLp_r) begin
        // l2/l3 ready only after the ack
        linkSt_r[p] <= swp_pkg::SWP_LK_L23;
      end else begin
        unique case (linkSt_r[p])
          swp_pkg::SWP_LK_L0, swp_pkg::SWP_LK_L0S: begin
            if (p == 0 && l1Want) begin
              // request l1 from l0 or l0s
              linkSt_r[p] <= swp_pkg::SWP_LK_L1PEND;
            end else if (p != 0 && dState_r[p] == swp_pkg::SWP_D3_HOT &&
                         portIn[p].peerL1) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L1;
            end else if (l0sGo) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L0S;
            end else if (!portIn[p].idle) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L0;
            end
          end
          // wait for the ack, give up on activity unless in d3hot
          swp_pkg::SWP_LK_L1PEND: begin
            if (portIn[p].peerL1) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L1;
            end else if (!l1Want && !portIn[p].idle) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L0;
            end
          end
          // leave l1 on traffic unless held there by d3hot
          swp_pkg::SWP_LK_L1: begin
            if (!portIn[p].idle && dState_r[p] != swp_pkg::SWP_D3_HOT) begin
              linkSt_r[p] <= swp_pkg::SWP_LK_L0;
            end
          end
          // switch left low power: retrain to l0
          swp_pkg::SWP_LK_L23: begin
            linkSt_r[p] <= swp_pkg::SWP_LK_L0;
          end
        endcase
      end
    end

    // registered port outputs, one cycle behind the state
    // built only from this port's state
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        portStat[p] <= '{linkState: swp_pkg::SWP_LK_L0, default: 1'b0};
      end else begin
        portStat[p].linkState   <= linkSt_r[p];
        portStat[p].l1Req       <= (p == 0) &&
                                   (linkSt_r[p] == swp_pkg::SWP_LK_L1PEND);
        portStat[p].l1Permit    <= (dState_r[p] == swp_pkg::SWP_D3_HOT);
        portStat[p].pmeOk       <= (dState_r[p] == swp_pkg::SWP_D0_UNINIT) ||
                                   (dState_r[p] == swp_pkg::SWP_D0_ACTIVE);
        portStat[p].trafficStop <= (linkSt_r[p] == swp_pkg::SWP_LK_L23);
      end
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rdNxt = 32'h0000_0000;
    if (addrOk) begin
      unique case (hitReg)
        2'h0: rdNxt[`SWP_PS_MSB:`SWP_PS_LSB] =
                (dState_r[hitPort] == swp_pkg::SWP_D3_HOT ||
                 dState_r[hitPort] == swp_pkg::SWP_D3_COLD) ?
                `SWP_PS_D3HOT : `SWP_PS_D0;
        2'h1: rdNxt[1:0] = aspm_r[hitPort];
        2'h2: begin
          rdNxt[`SWP_L0S_TMR_LSB +: `SWP_TMR_W] = l0sTmr_r[hitPort];
          rdNxt[`SWP_L1_TMR_LSB +: `SWP_TMR_W]  = l1Tmr_r[hitPort];
        end
        2'h3: begin
          rdNxt[`SWP_ST_DSTATE_LSB +: 4] = dState_r[hitPort];
          rdNxt[`SWP_ST_LINK_LSB +: 5]   = linkSt_r[hitPort];
          rdNxt[`SWP_ST_DEVLP_BIT]       = devLp_r;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdNxt;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync_n);

  chk_pme_off_d3: assert property (
    dState_r[0] == swp_pkg::SWP_D3_HOT |=> !portStat[0].pmeOk)
    else $error("pme allowed in d3hot");
  chk_no_req_c: assert property (
    !portStat[1].l1Req) else $error("port c asked for l1");
  chk_no_aspm_l1_c: assert property (
    !aspm_r[1][`SWP_ASPM_L1_BIT]) else $error("l1 aspm on port c");
  chk_d3_entry: assert property (
    dState_r[0] == swp_pkg::SWP_D0_ACTIVE && regWr && regAddr == `SWP_OFS_PM_CONTROL_STATUS_REG &&
    regWdata[1:0] == `SWP_PS_D3HOT |=> dState_r[0] == swp_pkg::SWP_D3_HOT)
    else $error("d3hot write not taken");
  // port c is the port that the bench brings back from d3hot
  chk_d0_return: assert property (
    dState_r[1] == swp_pkg::SWP_D3_HOT && !pwrGone_r && regWr &&
    regAddr == (`SWP_PORT_STRIDE + `SWP_OFS_PM_CONTROL_STATUS_REG) && regWdata[1:0] == `SWP_PS_D0
    |=> dState_r[1] == swp_pkg::SWP_D0_UNINIT && $stable(aspm_r[1]))
    else $error("d0 write not taken or registers changed");
  chk_l1_needs_ack: assert property (
    linkSt_r[0] == swp_pkg::SWP_LK_L1PEND && !portIn[0].peerL1 && !devLp_r
    |=> linkSt_r[0] != swp_pkg::SWP_LK_L1) else $error("l1 without ack");
  chk_l0s_hold: assert property (
    linkSt_r[1] == swp_pkg::SWP_LK_L0 ##1 linkSt_r[1] == swp_pkg::SWP_LK_L0S
    |-> $past(idleCnt_r[1]) >= $past(l0sTmr_r[1])) else $error("early l0s");
  chk_req_out: assert property (
    linkSt_r[0] == swp_pkg::SWP_LK_L1PEND |=> portStat[0].l1Req)
    else $error("l1 request not driven");
  chk_dev_lowpwr: assert property (
    devLp_r |-> $past(toAck_r) && dState_r[0] != swp_pkg::SWP_D0_ACTIVE)
    else $error("switch low power without root d3 and ack");
  chk_l23_quiet: assert property (
    linkSt_r[1] == swp_pkg::SWP_LK_L23 |=> portStat[1].trafficStop)
    else $error("traffic not stopped in l2/l3");

  cov_l0s: cover property (linkSt_r[1] == swp_pkg::SWP_LK_L0S);
  cov_l1_port_a: cover property (linkSt_r[0] == swp_pkg::SWP_LK_L1);
  cov_d3_cold: cover property (dState_r[0] == swp_pkg::SWP_D3_COLD);
  cov_dev_lp: cover property (deviceLowPower);

endmodule // swp_power_ctrl

`default_nettype wire

// ### tb/swp_link_partner.sv
/*
  link partner model for both bridge ports of the power control block.
  assumes the bench sets idle levels and chooses how port a answers l1.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_link_partner (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire swp_pkg::swpPortStat_t [1:0] portStat,
  input  wire logic [1:0]                  idleLvl,
  input  wire logic                        ackOn,
  input  wire logic [3:0]                  ackDelay,
  input  wire logic                        askL1C,
  output swp_pkg::swpPortIn_t [1:0]        portIn
);
  logic [3:0] waitCnt_r; // cycles the open request has waited
  logic       ackA_r;    // acknowledge level towards port a

  // answer only when allowed, after a delay
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt_r <= 4'h0;
      ackA_r    <= 1'h0;
    end else if (portStat[0].l1Req && ackOn) begin
      // a slow partner lets the request sit first
      if (waitCnt_r >= ackDelay) begin
        ackA_r <= 1'h1;
      end else begin
        waitCnt_r <= waitCnt_r + 4'h1;
      end
    end else begin
      // no request, or refusing: never acknowledge
      waitCnt_r <= 4'h0;
      ackA_r    <= 1'h0;
    end
  end

  // idle levels pass straight through; port c asks on command
  always_comb begin
    portIn[0].idle   = idleLvl[0];
    portIn[0].peerL1 = ackA_r;
    portIn[1].idle   = idleLvl[1];
    portIn[1].peerL1 = askL1C;
  end
endmodule // swp_link_partner
`default_nettype wire

// ### tb/swp_power_ctrl_test.sv
/*
  self-checking bench for the switch power and link power control block.
  assumes the design's register map constants and one partner model for both ports.
*/
`include "swp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module swp_power_ctrl_test;
  localparam int LIMIT = 20000; // run ceiling in clock cycles

  logic                        sys_clk;
  logic                        arst_n;
  logic [7:0]                  regAddr;
  logic [31:0]                 regWdata;
  logic                        regWr;
  logic                        regRd;
  logic [31:0]                 regRdata;
  swp_pkg::swpPortIn_t  [1:0]  portIn;
  swp_pkg::swpPortStat_t [1:0] portStat;
  logic                        turnOffAck;
  logic                        powerRemoved;
  logic                        deviceLowPower;
  logic [1:0]                  idleLvl;   // entry conditions per port
  logic                        ackOn;     // partner acknowledges l1
  logic [3:0]                  ackDelay;  // partner answer delay
  logic                        askL1C;    // port c partner asks l1
  int                          cycles;
  int                          mismatches;
  int                          compares;

  swp_power_ctrl i_swp_power_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .portIn(portIn), .turnOffAck(turnOffAck), .powerRemoved(powerRemoved),
    .portStat(portStat), .deviceLowPower(deviceLowPower));

  swp_link_partner i_swp_link_partner (.sys_clk(sys_clk), .arst_n(arst_n),
    .portStat(portStat), .idleLvl(idleLvl), .ackOn(ackOn), .ackDelay(ackDelay),
    .askL1C(askL1C), .portIn(portIn));

  // free running clock, 25 ns
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // verdict, the one place the run ends
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // compare with case inequality so unknowns never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // base address of a port's register group
  function automatic logic [7:0] base(input int p);
    return (p == 1) ? `SWP_PORT_STRIDE : 8'h00;
  endfunction

  // status word as read back
  function automatic logic [31:0] stWord(input logic [3:0] d, input logic [4:0] l,
                                         input logic lp);
    return {22'h0, lp, l, d};
  endfunction

  // one-cycle write strobe
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'h1;
    @(posedge sys_clk);
    regWr    <= 1'h0;
  endtask

  // read: data only in the cycle after the strobe, zero after that
  task automatic regRead(input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask = 32'hFFFFFFFF);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge sys_clk);
    regRd   <= 1'h0;
    @(negedge sys_clk);
    check(regRdata & mask, exp);
    @(negedge sys_clk);
    check(regRdata, 32'h0);
  endtask

  // bounded wait for a link state, then compare
  task automatic waitLink(input int p, input swp_pkg::swpLink_t st, input int maxCyc);
    int n;
    n = 0;
    while (portStat[p].linkState !== st && n < maxCyc) begin
      @(negedge sys_clk);
      n++;
    end
    check(32'(portStat[p].linkState), 32'(st));
  endtask

  // hang guard: counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("CHECK FAILED at %0t: cycles %h expected below %h", $time, cycles, LIMIT);
      summarize();
    end
  end

  always @(negedge sys_clk) begin
    if (portStat[1].l1Req === 1'h1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: port c request %h expected %h", $time, 1'h1, 1'h0);
    end
  end

  // main sequence
  initial begin
    arst_n = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    turnOffAck = 1'h0;
    powerRemoved = 1'h0;
    idleLvl = 2'h0;
    ackOn = 1'h0;
    ackDelay = 4'h3;
    askL1C = 1'h0;
    cycles = 0;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    // reset contents of both groups, then an unmapped place
    for (int p = 0; p < 2; p++) begin
      regRead(base(p) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h0);
      regRead(base(p) + `SWP_OFS_LINKCTL, 32'h0);
      regRead(base(p) + `SWP_OFS_PMVEND, {16'h0, `SWP_L1_TMR_RST, `SWP_L0S_TMR_RST});
      regRead(base(p) + `SWP_OFS_STATUS, stWord(4'h1, 5'h01, 1'h0));
    end
    regRead(8'h20, 32'h0);
    // configuring port c leaves port a uninitialised
    regWrite(base(1) + `SWP_OFS_STATUS, 32'h1);
    regRead(base(0) + `SWP_OFS_STATUS, stWord(4'h1, 5'h01, 1'h0));
    regRead(base(1) + `SWP_OFS_STATUS, stWord(4'h2, 5'h01, 1'h0));
    regWrite(base(0) + `SWP_OFS_STATUS, 32'h1);
    @(negedge sys_clk);
    check(32'(portStat[0].pmeOk), 32'h1);
    // port c: l0s after six idle cycles, l1 enable bit refused
    regWrite(base(1) + `SWP_OFS_PMVEND, 32'h00004006);
    regWrite(base(1) + `SWP_OFS_LINKCTL, 32'h3);
    regRead(base(1) + `SWP_OFS_LINKCTL, 32'h1);
    @(posedge sys_clk);
    idleLvl <= 2'h2;
    repeat (3) @(negedge sys_clk);
    check(32'(portStat[1].linkState), 32'(swp_pkg::SWP_LK_L0));
    waitLink(1, swp_pkg::SWP_LK_L0S, 12);
    // port a: l1 after eight idle cycles, partner refuses first
    regWrite(base(0) + `SWP_OFS_PMVEND, 32'h000008FF);
    regWrite(base(0) + `SWP_OFS_LINKCTL, 32'h2);
    idleLvl <= 2'h3;
    repeat (3) @(negedge sys_clk);
    check(32'(portStat[0].linkState), 32'(swp_pkg::SWP_LK_L0));
    waitLink(0, swp_pkg::SWP_LK_L1PEND, 20);
    repeat (2) @(negedge sys_clk);
    check(32'(portStat[0].l1Req), 32'h1);
    repeat (40) @(negedge sys_clk);
    check(32'(portStat[0].linkState), 32'(swp_pkg::SWP_LK_L1PEND));
    @(posedge sys_clk);
    ackOn <= 1'h1;
    waitLink(0, swp_pkg::SWP_LK_L1, 12);
    regRead(base(0) + `SWP_OFS_STATUS, stWord(4'h2, 5'h08, 1'h0));
    @(posedge sys_clk);
    idleLvl <= 2'h2;
    waitLink(0, swp_pkg::SWP_LK_L0, 10);
    // port c to d3hot: only port c changes
    regWrite(base(1) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h3);
    regRead(base(1) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h3);
    regRead(base(1) + `SWP_OFS_STATUS, 32'h4, 32'hF);
    check(32'(portStat[1].l1Permit), 32'h1);
    check(32'(portStat[1].pmeOk), 32'h0);
    check(32'(portStat[0].pmeOk), 32'h1);
    regRead(base(0) + `SWP_OFS_STATUS, 32'h2, 32'hF);
    @(posedge sys_clk);
    askL1C <= 1'h1;
    waitLink(1, swp_pkg::SWP_LK_L1, 10);
    @(posedge sys_clk);
    askL1C <= 1'h0;
    // back to d0: uninitialised, settings kept
    regWrite(base(1) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h0);
    regRead(base(1) + `SWP_OFS_STATUS, 32'h1, 32'hF);
    regRead(base(1) + `SWP_OFS_PMVEND, 32'h00004006);
    regRead(base(1) + `SWP_OFS_LINKCTL, 32'h1);
    // root port d3hot, then turn-off acknowledge: whole switch low
    regWrite(base(0) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h3);
    waitLink(0, swp_pkg::SWP_LK_L1, 20);
    check(32'(portStat[0].l1Permit), 32'h1);
    check(32'(deviceLowPower), 32'h0);
    @(posedge sys_clk);
    turnOffAck <= 1'h1;
    @(posedge sys_clk);
    turnOffAck <= 1'h0;
    repeat (4) @(negedge sys_clk);
    check(32'(deviceLowPower), 32'h1);
    waitLink(0, swp_pkg::SWP_LK_L23, 6);
    waitLink(1, swp_pkg::SWP_LK_L23, 6);
    check(32'({portStat[1].trafficStop, portStat[0].trafficStop}), 32'h3);
    check(32'(portStat[0].pmeOk), 32'h0);
    // port c to d3cold by power removal
    regWrite(base(1) + `SWP_OFS_STATUS, 32'h1);
    regWrite(base(1) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h3);
    powerRemoved <= 1'h1;
    repeat (8) @(posedge sys_clk);
    regRead(base(1) + `SWP_OFS_STATUS, 32'h8, 32'hF);
    regRead(base(1) + `SWP_OFS_PM_CONTROL_STATUS_REG, 32'h3);
    // second reset in mid-run returns every port to d0 uninitialised
    @(posedge sys_clk);
    arst_n <= 1'h0;
    powerRemoved <= 1'h0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    regRead(base(1) + `SWP_OFS_STATUS, stWord(4'h1, 5'h01, 1'h0));
    regRead(base(0) + `SWP_OFS_STATUS, stWord(4'h1, 5'h01, 1'h0));
    summarize();
  end
endmodule // swp_power_ctrl_test
`default_nettype wire
